// [design/bis_defines.svh]
/*
 Constants of the holding-brake interlock sequencer: register offsets,
 field widths, reset values and timing counts.
 Assumes inclusion by bare name from design and sim files.
*/
`ifndef BIS_DEFINES_SVH
`define BIS_DEFINES_SVH

////////////////////////////////////////////////////////////////////////
// register byte offsets
`define BIS_ADDR_W         8
`define BIS_OFS_OUT_SEL    8'h00
`define BIS_OFS_SON_DELAY  8'h04
`define BIS_OFS_BASE_WAIT  8'h08
`define BIS_OFS_BRK_SPEED  8'h0C
`define BIS_OFS_BRK_TIME   8'h10
`define BIS_OFS_STATUS     8'h14

////////////////////////////////////////////////////////////////////////
// field widths, reset values and selector codes
`define BIS_SEL_W          12
`define BIS_DELAY_W        12
`define BIS_WAIT_W         9
`define BIS_SPEED_W        7
`define BIS_TIME_W         7
`define BIS_RST_OUT_SEL    12'h210
`define BIS_RST_SON_DELAY  12'h000
`define BIS_RST_BASE_WAIT  9'h000
`define BIS_RST_BRK_SPEED  7'h64
`define BIS_RST_BRK_TIME   7'h32
`define BIS_CODE_BRAKE     4'h4
`define BIS_CODE_MAX       4'h9

////////////////////////////////////////////////////////////////////////
// timing
`define BIS_CLK_NS         8
`define BIS_MS_NS          1000000
`define BIS_CYC_PER_MS     (`BIS_MS_NS / `BIS_CLK_NS)
`define BIS_MS_PER_TICK10  10

////////////////////////////////////////////////////////////////////////
// bus answers
`define BIS_RESP_OKAY      2'h0
`define BIS_RESP_SLVERR    2'h2

`endif

// [design/bis_pkg.sv]
/*
 Types of the holding-brake interlock sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bis_pkg;

	// sequencer states, gray along off -> on -> stop
	typedef enum logic [2:0] {
		BIS_ST_OFF      = 3'h0,
		BIS_ST_ON_WAIT  = 3'h1,
		BIS_ST_ON       = 3'h3,
		BIS_ST_RUN_STOP = 3'h2,
		BIS_ST_STOP_DLY = 3'h6
	} bis_state_e;

	// drive status functions that may share output terminals
	typedef struct packed {
		logic torque_detect_out;
		logic homing_done_out;
		logic excitation_out;
		logic overtravel_out;
		logic index_pulse_out;
		logic torque_limited_out;
		logic drive_ready_out;
		logic rotating_out;
		logic position_reached_out;
	} bis_status_s;

	typedef logic [9:0] bis_func_t;

endpackage

// [design/bis_tick_div.sv]
/*
 Divider giving one-cycle 1 ms and 10 ms enable pulses.
 Assumes a single free-running clock and synchronous reset.
*/
`include "bis_defines.svh"

module bis_tick_div #(
	parameter int CYC_PER_MS = 125000
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// enables
	output logic      ms_tick,
	output logic      tick10
);

	localparam int CW = $clog2(CYC_PER_MS + 1);

	logic [CW-1:0] cyc_cnt;
	logic [3:0]    ms_cnt;
	wire           cyc_wrap = (cyc_cnt == CW'(CYC_PER_MS - 1));
	wire           ms_wrap  = (ms_cnt == 4'(`BIS_MS_PER_TICK10 - 1));

	generate
		if (CYC_PER_MS < 1) begin : g_bad
			$error("CYC_PER_MS must be at least one");
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_cnt <= '0;
			ms_cnt  <= 4'h0;
			ms_tick <= 1'b0;
			tick10  <= 1'b0;
		end else begin
			cyc_cnt <= cyc_wrap ? '0 : cyc_cnt + CW'(1);
			ms_tick <= cyc_wrap;
			tick10  <= cyc_wrap && ms_wrap;
			if (cyc_wrap)
				ms_cnt <= ms_wrap ? 4'h0 : ms_cnt + 4'h1;
		end
	end

endmodule

// [design/bis_top.sv]
/*
 Holding-brake interlock sequencer with AXI4-Lite register access.
 Decides servo enable and brake release from the servo request, alarm
 and motor speed, and routes status functions to three output terminals.
 Assumes all inputs synchronous to aclk; motor_speed is |rpm|.
*/
// The AXI4-Lite register port and the register offsets were left to the implementer.
`include "bis_defines.svh"

module bis_top #(
	parameter int CYC_PER_MS = `BIS_CYC_PER_MS
) (
	// clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// axi4-lite write address
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [`BIS_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	// axi4-lite write data
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	// axi4-lite write response
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	output logic [1:0]                  s_axi_bresp,
	// axi4-lite read address
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	input  wire logic [`BIS_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	// axi4-lite read data
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	// drive side
	input  wire logic                   servo_on_req,
	input  wire logic                   alarm,
	input  wire logic [15:0]            motor_speed,
	input  wire bis_pkg::bis_status_s   status_in,
	// outputs
	output logic                        servo_enable,
	output logic                        brake_release_out_n,
	output logic [2:0]                  term_out_n
);
	import bis_pkg::*;

	////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] data,
	                                      input logic [3:0]  strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[8*i +: 8] = data[8*i +: 8];
		end
		return res;
	endfunction

	// one selector digit picks one function; codes above 9 drive nothing
	function automatic logic route(input logic [3:0] code,
	                               input bis_func_t  funcs);
		return (code <= `BIS_CODE_MAX) ? funcs[code] : 1'b0;
	endfunction

	////////////////////////////////////////////////////////////////////
	// registers

	logic [`BIS_SEL_W-1:0]   out_sel;
	logic [`BIS_DELAY_W-1:0] son_delay;
	logic [`BIS_WAIT_W-1:0]  base_wait;
	logic [`BIS_SPEED_W-1:0] brk_speed;
	logic [`BIS_TIME_W-1:0]  brk_time;

	bis_state_e state;
	bis_state_e next_state;
	logic [11:0] ms_cnt;
	logic [9:0]  tmo_cnt;
	logic        rel;
	logic        next_rel;
	logic        next_en;

	////////////////////////////////////////////////////////////////////
	// bus slave

	logic        aw_held;
	logic        w_held;
	logic [`BIS_ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;

	wire aw_hs  = s_axi_awvalid && s_axi_awready;
	wire w_hs   = s_axi_wvalid && s_axi_wready;
	wire ar_hs  = s_axi_arvalid && s_axi_arready;
	wire do_wr  = aw_held && w_held && !s_axi_bvalid;
	wire [`BIS_ADDR_W-1:0] wa = wr_addr;
	wire [`BIS_ADDR_W-1:0] ra = s_axi_araddr;

	wire wr_sel   = (wa == `BIS_OFS_OUT_SEL);
	wire wr_dly   = (wa == `BIS_OFS_SON_DELAY);
	wire wr_wait  = (wa == `BIS_OFS_BASE_WAIT);
	wire wr_spd   = (wa == `BIS_OFS_BRK_SPEED);
	wire wr_tim   = (wa == `BIS_OFS_BRK_TIME);
	wire wr_hit   = wr_sel || wr_dly || wr_wait || wr_spd || wr_tim;

	wire [31:0] merged_sel  = merge(32'(out_sel),   wr_data, wr_strb);
	wire [31:0] merged_dly  = merge(32'(son_delay), wr_data, wr_strb);
	wire [31:0] merged_wait = merge(32'(base_wait), wr_data, wr_strb);
	wire [31:0] merged_spd  = merge(32'(brk_speed), wr_data, wr_strb);
	wire [31:0] merged_tim  = merge(32'(brk_time),  wr_data, wr_strb);

	wire [31:0] status_word = {tmo_cnt, 4'h0, ms_cnt, 3'(state), rel,
	                           servo_enable, 1'b0};
	wire rd_hit = (ra == `BIS_OFS_OUT_SEL) || (ra == `BIS_OFS_SON_DELAY) ||
	              (ra == `BIS_OFS_BASE_WAIT) || (ra == `BIS_OFS_BRK_SPEED) ||
	              (ra == `BIS_OFS_BRK_TIME) || (ra == `BIS_OFS_STATUS);
	wire [31:0] rd_word =
		(ra == `BIS_OFS_OUT_SEL)   ? 32'(out_sel) :
		(ra == `BIS_OFS_SON_DELAY) ? {{20{son_delay[11]}}, son_delay} :
		(ra == `BIS_OFS_BASE_WAIT) ? 32'(base_wait) :
		(ra == `BIS_OFS_BRK_SPEED) ? 32'(brk_speed) :
		(ra == `BIS_OFS_BRK_TIME)  ? 32'(brk_time) :
		(ra == `BIS_OFS_STATUS)    ? status_word : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			wr_addr <= '0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			if (aw_hs) begin
				aw_held <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_held <= 1'b0;
			end
			if (w_hs) begin
				w_held  <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end else if (do_wr) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `BIS_RESP_OKAY;
		end else begin
			if (aw_hs)
				s_axi_awready <= 1'b0;
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_awready <= 1'b1;
			if (w_hs)
				s_axi_wready <= 1'b0;
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_wready <= 1'b1;
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `BIS_RESP_OKAY : `BIS_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `BIS_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? `BIS_RESP_OKAY : `BIS_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// reset selector holds no brake code, so the brake drives nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_sel   <= `BIS_RST_OUT_SEL;
			son_delay <= `BIS_RST_SON_DELAY;
			base_wait <= `BIS_RST_BASE_WAIT;
			brk_speed <= `BIS_RST_BRK_SPEED;
			brk_time  <= `BIS_RST_BRK_TIME;
		end else if (do_wr) begin
			if (wr_sel)
				out_sel <= merged_sel[`BIS_SEL_W-1:0];
			if (wr_dly)
				son_delay <= merged_dly[`BIS_DELAY_W-1:0];
			if (wr_wait)
				base_wait <= merged_wait[`BIS_WAIT_W-1:0];
			if (wr_spd)
				brk_speed <= merged_spd[`BIS_SPEED_W-1:0];
			if (wr_tim)
				brk_time <= merged_tim[`BIS_TIME_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// timebase

	logic ms_tick;
	logic tick10;

	bis_tick_div #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ms_tick (ms_tick),
		.tick10  (tick10)
	);

	////////////////////////////////////////////////////////////////////
	// brake sequencer

	wire        stop_req  = alarm || !servo_on_req;
	wire        start_req = servo_on_req && !alarm;
	wire        running   = motor_speed >= 16'(brk_speed);
	wire        slow      = motor_speed < 16'(brk_speed);
	wire        tmo_done  = tmo_cnt >= 10'(brk_time);
	wire        wait_done = tmo_cnt >= 10'(base_wait);
	wire        dly_neg   = son_delay[`BIS_DELAY_W-1];
	wire        dly_zero  = (son_delay == '0);
	wire [11:0] dly_mag   = dly_neg ? 12'(-son_delay) : son_delay;
	wire        dly_done  = ms_cnt >= dly_mag;

	always_comb begin
		next_state = state;
		next_rel   = rel;
		next_en    = servo_enable;
		unique case (state)
			BIS_ST_OFF: begin
				if (start_req) begin
					next_state = BIS_ST_ON_WAIT;
					next_en    = 1'b1;
				end
			end
			BIS_ST_ON_WAIT: begin
				if (stop_req) begin
					next_state = BIS_ST_OFF;
					next_en    = 1'b0;
				end else if (wait_done) begin
					next_state = BIS_ST_ON;
					next_rel   = 1'b1;
				end
			end
			BIS_ST_ON: begin
				if (stop_req && running) begin
					// servo off or alarm while moving
					next_state = BIS_ST_RUN_STOP;
					next_en    = 1'b0;
				end else if (stop_req && (alarm || dly_zero)) begin
					next_state = BIS_ST_OFF;
					next_en    = 1'b0;
					next_rel   = 1'b0;
				end else if (stop_req) begin
					// positive delay: brake first; negative: servo first
					next_state = BIS_ST_STOP_DLY;
					next_en    = dly_neg ? 1'b0 : 1'b1;
					next_rel   = dly_neg ? 1'b1 : 1'b0;
				end
			end
			BIS_ST_STOP_DLY: begin
				// an alarm cuts the delay short in either direction
				if (dly_done || alarm) begin
					next_state = BIS_ST_OFF;
					next_en    = 1'b0;
					next_rel   = 1'b0;
				end
			end
			BIS_ST_RUN_STOP: begin
				if (start_req) begin
					next_state = BIS_ST_ON;
					next_en    = 1'b1;
				end else if (slow || tmo_done) begin
					next_state = BIS_ST_OFF;
					next_rel   = 1'b0;
				end
			end
			default: begin
				next_state = BIS_ST_OFF;
				next_en    = 1'b0;
				next_rel   = 1'b0;
			end
		endcase
	end

	wire leave  = (next_state != state);
	wire tmo_on = (state == BIS_ST_RUN_STOP) || (state == BIS_ST_ON_WAIT);

	// timeout counter restarts on every state change, so servo on clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state   <= BIS_ST_OFF;
			rel     <= 1'b0;
			ms_cnt  <= 12'h000;
			tmo_cnt <= 10'h000;
		end else begin
			state <= next_state;
			rel   <= next_rel;
			if (leave)
				ms_cnt <= 12'h000;
			else if (ms_tick && state == BIS_ST_STOP_DLY && !dly_done)
				ms_cnt <= ms_cnt + 12'h001;
			if (leave)
				tmo_cnt <= 10'h000;
			else if (tick10 && tmo_on && tmo_cnt != 10'h3FF)
				tmo_cnt <= tmo_cnt + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// output terminals

	bis_func_t funcs;
	assign funcs = {status_in[8:4], next_rel, status_in[3:0]};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			servo_enable        <= 1'b0;
			brake_release_out_n <= 1'b1;
		end else begin
			servo_enable        <= next_en;
			brake_release_out_n <= !next_rel;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_term
			wire [3:0] code = out_sel[4*g +: 4];
			// pin low is active; a brake code carries release low
			always_ff @(posedge aclk) begin
				if (!aresetn)
					term_out_n[g] <= 1'b1;
				else
					term_out_n[g] <= !route(code, funcs);
			end
		end
	endgenerate

endmodule

// [sim/bis_props.sv]
/*
 Port checker for bis_top.
 Assumes bind to bis_top and the brake speed threshold left at 100 rpm.
*/
`include "bis_defines.svh"

module bis_props (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// drive side
	input wire logic        servo_on_req,
	input wire logic        alarm,
	input wire logic [15:0] motor_speed,
	input wire logic        servo_enable,
	input wire logic        brake_release_out_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import bis_pkg::*;
	localparam int TMO_MAX = 2100;
	logic [11:0] off_cnt;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles with servo off while the brake is still released
	always_ff @(posedge aclk) begin
		if (!aresetn || servo_enable || brake_release_out_n)
			off_cnt <= 12'h000;
		else
			off_cnt <= off_cnt + 12'h001;
	end
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	property p_rst_safe;
		disable iff (1'b0) !aresetn |=> !servo_enable && brake_release_out_n;
	endproperty
	property p_son;
		!servo_enable && brake_release_out_n && servo_on_req && !alarm
			|=> servo_enable;
	endproperty
	property p_alarm_off;
		alarm && servo_enable |=> !servo_enable;
	endproperty
	property p_rel_on;
		$fell(brake_release_out_n) |-> servo_enable;
	endproperty
	property p_slow_apply;
		alarm && !brake_release_out_n && motor_speed < 16'h0064
			|=> brake_release_out_n;
	endproperty
	property p_tmo;
		off_cnt <= TMO_MAX;
	endproperty
	property p_b_stand;
		s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_r_stand;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_wr_ans;
		s_wr_taken |-> ##2 s_axi_bvalid;
	endproperty
	property p_rd_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rst_safe: assert property (p_rst_safe)
		else $error("outputs not safe in reset");
	a_son: assert property (p_son)
		else $error("servo enable missed");
	a_alarm_off: assert property (p_alarm_off)
		else $error("alarm kept servo on");
	a_rel_on: assert property (p_rel_on)
		else $error("brake released without servo");
	a_slow_apply: assert property (p_slow_apply)
		else $error("brake not applied at low speed");
	a_tmo: assert property (p_tmo)
		else $error("brake timeout overrun");
	a_b_stand: assert property (p_b_stand)
		else $error("write response dropped");
	a_r_stand: assert property (p_r_stand)
		else $error("read data dropped");
	a_wr_ans: assert property (p_wr_ans)
		else $error("write response late");
	a_rd_ans: assert property (p_rd_ans)
		else $error("read data late");
endmodule

// [sim/bis_relay.sv]
/*
 Brake control relay: the coil pulls in after a few cycles of low drive.
 Assumes one clock shared with the sequencer.
*/
module bis_relay #(
	parameter int PICK = 3
) (
	input  wire logic aclk,
	input  wire logic brake_release_out_n,
	output logic      brake_held
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [PICK-1:0] coil = '0;
	initial brake_held = 1'b1;
	// low drive energizes the coil and lifts the brake
	always @(posedge aclk) begin
		coil <= {coil[PICK-2:0], ~brake_release_out_n};
		brake_held <= ~coil[PICK-1];
	end
endmodule

// [sim/brake_interlock_sequencer_bench.sv]
/*
 Self-checking bench of bis_top with a relay on the brake output.
 Assumes CYC_PER_MS of 4, so a 10 ms tick is 40 cycles.
*/
module brake_interlock_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import bis_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, son = 1'b0, alm = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdat;
	logic [15:0] spd = 16'h0;
	logic [8:0] stv = 9'h0A5;
	logic awr, wrd, bv, arr, rv, en, brk, held;
	logic [1:0] br, rr, r;
	logic [2:0] term;
	int n_fail = 0, n_checks = 0, n;
	always #4 aclk = ~aclk;
	bis_top #(.CYC_PER_MS(4)) DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .servo_on_req(son), .alarm(alm),
		.motor_speed(spd), .status_in(bis_status_s'(stv)),
		.servo_enable(en), .brake_release_out_n(brk), .term_out_n(term));
	bis_relay u_relay (.aclk(aclk), .brake_release_out_n(brk),
		.brake_held(held));
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge aclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge aclk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wrd)
				wv <= 1'b0;
		end while (bv !== 1'b1);
		bry <= 1'b0;
		r = br;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge aclk);
			if (arv && arr)
				arv <= 1'b0;
		end while (rv !== 1'b1);
		rry <= 1'b0;
		d = rdat;
		r = rr;
	endtask
	// wait for enable (sel 1) or brake pin (sel 0) to reach v
	task automatic wt(input logic v, input bit sel);
		n = 0;
		while (((sel ? en : brk) !== v) && n < 400) begin
			step(1);
			n++;
		end
	endtask
	task automatic drv(input logic on, input logic al, input int k);
		@(posedge aclk);
		son <= on;
		alm <= al;
		step(k);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [31:0] d;
		logic [31:0] exp_v [5];
		exp_v = '{32'h210, 32'h0, 32'h0, 32'h64, 32'h32};
		for (int i = 0; i < 5; i++) begin
			rd(8'(i * 4), d);
			chk("reset value", exp_v[i], d);
		end
		rd(8'h18, d);
		chk("unmapped read", 32'h2, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		wr(8'h18, 32'h5);
		chk("unmapped write", 32'h2, {30'h0, r});
		$display("test regs done");
	endtask
	task automatic t_default;
		logic [31:0] d;
		stv <= 9'h000;
		drv(1'b1, 1'b0, 3);
		chk("brake released", 32'h0, brk);
		chk("terminals idle", 32'h7, term);
		rd(8'h14, d);
		chk("status on", 32'h1E, d);
		step(1);
		chk("relay lifts", 32'h0, held);
		drv(1'b0, 1'b0, 1);
		chk("servo off", 32'h0, en);
		chk("brake applied", 32'h1, brk);
		step(4);
		chk("relay holds", 32'h1, held);
		$display("test default done");
	endtask
	task automatic t_codes;
		logic act;
		@(posedge aclk);
		stv <= 9'h0A5;
		for (int c = 0; c < 10; c++) begin
			wr(8'h00, {20'h0, c[3:0], c[3:0], c[3:0]});
			step(2);
			act = (c == 4) ? 1'b0 : stv[(c < 4) ? c : c - 1];
			chk("code terminals", {29'h0, {3{~act}}}, term);
		end
		wr(8'h00, 32'h444);
		drv(1'b1, 1'b0, 3);
		chk("brake terminals", 32'h0, term);
		drv(1'b0, 1'b0, 1);
		chk("brake terminals off", 32'h7, term);
		$display("test codes done");
	endtask
	task automatic t_delay;
		wr(8'h04, 32'h3);
		drv(1'b1, 1'b0, 3);
		drv(1'b0, 1'b0, 1);
		chk("pos brake", 32'h1, brk);
		chk("pos enable", 32'h1, en);
		wt(1'b0, 1'b1);
		chk("pos span", 32'h1, n >= 6 && n <= 16);
		wr(8'h04, 32'hFFD);
		drv(1'b1, 1'b0, 3);
		drv(1'b0, 1'b0, 1);
		chk("neg enable", 32'h0, en);
		chk("neg brake", 32'h0, brk);
		wt(1'b1, 1'b0);
		chk("neg span", 32'h1, n >= 6 && n <= 16);
		$display("test delay done");
	endtask
	task automatic t_alarm;
		wr(8'h04, 32'h3);
		drv(1'b1, 1'b0, 3);
		drv(1'b1, 1'b1, 1);
		chk("alarm enable", 32'h0, en);
		chk("alarm brake", 32'h1, brk);
		wr(8'h04, 32'hFFD);
		drv(1'b1, 1'b0, 3);
		drv(1'b0, 1'b0, 1);
		drv(1'b0, 1'b1, 1);
		chk("alarm ends delay", 32'h1, brk);
		wr(8'h04, 32'h0);
		spd <= 16'd500;
		drv(1'b1, 1'b0, 3);
		drv(1'b1, 1'b1, 1);
		chk("run enable", 32'h0, en);
		chk("run brake", 32'h0, brk);
		@(posedge aclk);
		spd <= 16'd100;
		step(2);
		chk("at threshold", 32'h0, brk);
		@(posedge aclk);
		spd <= 16'd99;
		step(2);
		chk("below threshold", 32'h1, brk);
		drv(1'b0, 1'b0, 2);
		$display("test alarm done");
	endtask
	task automatic t_tmo;
		wr(8'h10, 32'h2);
		spd <= 16'd500;
		drv(1'b1, 1'b0, 3);
		drv(1'b0, 1'b0, 30);
		drv(1'b1, 1'b0, 1);
		chk("back on", 32'h1, en);
		drv(1'b1, 1'b0, 2);
		drv(1'b0, 1'b0, 1);
		wt(1'b1, 1'b0);
		chk("timeout span", 32'h1, n >= 38 && n <= 84);
		@(posedge aclk);
		spd <= 16'd0;
		$display("test timeout done");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_default();
		t_codes();
		t_delay();
		t_alarm();
		t_tmo();
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		stop_test();
	end
endmodule

bind bis_top bis_props u_props (.*);
